// [verif/cpu_periph_model.sv]
`timescale 1ns/100ps
// peripherals and cpu core on the far side of the flag bank
// pulse map: 0..2 unit1 capture/compare/pwm, 3..5 the same for unit2,
// 6 nonvolatile done, 7 rollover, 8 shutdown, 9 irq taken, 10 irq return
module cpu_periph_model (
  input  wire logic        mclk,
  output logic      [10:0] pulse_q  // one-hot event pulses
);
  // quiet from time zero so no event lands during reset
  initial pulse_q = 11'h000;

  // every event lasts exactly one edge; a held level would set it twice
  task automatic fire(input int idx);
    @(posedge mclk);
    pulse_q <= 11'h001 << idx;
    @(posedge mclk);
    pulse_q <= 11'h000;
  endtask
endmodule

// [verif/tb_irq_flags_doze_control.sv]
`timescale 1ns/100ps
`include "irq_doze_defines.svh"
// bench for the flag bank and cpu throttle; read data checked in order
module tb_irq_flags_doze_control;
  logic        mclk;        // system clock
  logic        sys_rst;     // async reset
  logic [7:0]  wb_adr_i;    // bus address
  logic [31:0] wb_dat_i;    // bus write data
  logic [31:0] wb_dat_o;    // bus read data
  logic        wb_we_i;     // bus direction
  logic [3:0]  wb_sel_i;    // byte enables
  logic        wb_cyc_i;    // bus cycle
  logic        wb_stb_i;    // bus strobe
  logic        wb_ack_o;    // bus answer
  logic [1:0]  mode1;       // unit1 mode
  logic [1:0]  mode2;       // unit2 mode
  logic [10:0] pulse_q;     // model events
  logic        irq_request; // cpu request level
  logic        edge_sel;    // edge select level
  logic        cpu_run;     // cpu executes
  logic        periph_run;  // peripherals clocked
  logic [31:0] exp_q[$];    // expected read data, oldest first
  logic [31:0] seed;        // xorshift state
  int          bad_count;   // mismatches
  int          n_tests;     // comparisons

  irq_flags_doze_control i_irq_flags_doze_control (
    .mclk(mclk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .capture_unit1_mode(mode1),
    .unit1_capture(pulse_q[0]), .unit1_compare_match(pulse_q[1]),
    .unit1_pwm_trailing(pulse_q[2]), .capture_unit2_mode(mode2),
    .unit2_capture(pulse_q[3]), .unit2_compare_match(pulse_q[4]),
    .unit2_pwm_trailing(pulse_q[5]), .nonvolatile_done(pulse_q[6]),
    .oscillator_rollover(pulse_q[7]), .waveform_shutdown(pulse_q[8]),
    .irq_taken(pulse_q[9]), .irq_return(pulse_q[10]),
    .irq_request(irq_request), .external_edge_select(edge_sel),
    .cpu_run(cpu_run), .periph_run(periph_run));

  cpu_periph_model i_cpu_periph_model (.mclk(mclk), .pulse_q(pulse_q));

  // free-running 100 MHz clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // fixed-seed xorshift, so every run repeats the same values
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // implemented bits of bank register i
  function automatic logic [7:0] mask_of(input int i);
    logic [63:0] m;
    m = `BANK_MASKS;
    return m[8*i +: 8];
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // one classic cycle; held until ack is sampled high, then released
  task automatic wb_cycle(input logic [7:0] adr, input logic we,
                          input logic [3:0] sel, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge mclk);
    wb_adr_i <= adr;
    wb_we_i  <= we;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wb_write(input logic [7:0] adr, input logic [31:0] dat);
    wb_cycle(adr, 1'b1, 4'hF, dat);
  endtask

  // the note goes into the queue before the request is raised
  task automatic wb_read(input logic [7:0] adr, input logic [7:0] exp);
    exp_q.push_back({24'h000000, exp});
    wb_cycle(adr, 1'b0, 4'hF, 32'h00000000);
  endtask

  // counts cycles until cpu_run shows the given level
  task automatic wait_run(input logic lvl, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (cpu_run !== lvl && n < 600);
  endtask

  // read answers are matched to the oldest note at the ack edge
  always @(posedge mclk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) bad_count++;
      else check(wb_dat_o, exp_q.pop_front());
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // the slowest ratio check alone needs over 512 cycles; the whole run a few thousand
  initial begin
    repeat (40000) @(posedge mclk);
    bad_count++;
    print_verdict();
  end

  initial begin
    logic [7:0] v;
    logic [7:0] a;
    int         p;
    {wb_adr_i, wb_dat_i, wb_we_i, wb_sel_i} = '0;
    {wb_cyc_i, wb_stb_i, mode1, mode2} = '0;
    seed = 32'h00000B9B;
    bad_count = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    // every register starts at zero
    wb_read(`GCTL_ADDR, `REG_RESET);
    wb_read(`THROTTLE_ADDR, `REG_RESET);
    for (int i = 0; i < 8; i++) begin
      wb_read(`ENABLE_BASE + 8'(4*i), `REG_RESET);
      wb_read(`FLAGS_BASE + 8'(4*i), `REG_RESET);
    end
    // random values: unimplemented bits must drop out
    for (int i = 0; i < 8; i++) begin
      v = 8'(xs());
      a = `ENABLE_BASE + 8'(4*i);
      wb_write(a, {24'hFFFFFF, v});
      wb_read(a, v & mask_of(i));
      a = `FLAGS_BASE + 8'(4*i);
      wb_write(a, {24'h000000, v});
      wb_read(a, v & mask_of(i));
      wb_write(a, 32'h00000000);
    end
    wb_write(`GCTL_ADDR, 32'h000000FF);
    wb_read(`GCTL_ADDR, `GCTL_MASK);
    check({31'h0, edge_sel}, 32'h1);
    // unmapped place and a write without byte 0 are both ignored
    wb_write(8'h48, 32'h000000FF);
    wb_read(8'h48, 8'h00);
    wb_cycle(`THROTTLE_ADDR, 1'b1, 4'hE, 32'h000000FF);
    wb_read(`THROTTLE_ADDR, 8'h00);
    // every mode against every unit event; only the matching one sets
    a = `FLAGS_BASE + 8'(4*`CAP_REG);
    for (int u = 0; u < 2; u++)
      for (int m = 0; m < 4; m++)
        for (int e = 0; e < 3; e++) begin
          if (u == 0) mode1 <= 2'(m);
          else mode2 <= 2'(m);
          i_cpu_periph_model.fire(3*u + e);
          v = (m == e + 1) ? 8'(1 << u) : 8'h00;
          wb_read(a, v);
          wb_write(a, 32'h00000000);
        end
    mode1 <= 2'h0;
    mode2 <= 2'h0;
    a = `FLAGS_BASE + 8'(4*`MISC_REG);
    for (int e = 0; e < 3; e++) begin
      i_cpu_periph_model.fire(6 + e);
      p = (e == 0) ? `NVM_BIT : (e == 1) ? `NCO_BIT : `CWG_BIT;
      wb_read(a, 8'(1 << p));
      wb_write(a, 32'h00000000);
    end
    // enabled flag reaches the cpu two cycles after its event
    wb_write(`ENABLE_BASE + 8'(4*`MISC_REG), 32'h00000020);
    wb_write(`GCTL_ADDR, 32'h000000C0);
    i_cpu_periph_model.fire(6);
    @(posedge mclk);
    @(negedge mclk);
    check({31'h0, irq_request}, 32'h1);
    wb_write(a, 32'h00000000);
    @(negedge mclk);
    check({31'h0, irq_request}, 32'h0);
    // period of the run pattern for every ratio code
    for (int r = 0; r < 8; r++) begin
      wb_write(`THROTTLE_ADDR, 32'h00000000);
      wb_write(`THROTTLE_ADDR, 32'h00000040 | r);
      wait_run(1'b0, p);
      wait_run(1'b1, p);
      wait_run(1'b1, p);
      check(p, 1 << (r + 1));
      check({31'h0, periph_run}, 32'h1);
    end
    // entry and return for all four enable and recovery settings
    for (int k = 0; k < 4; k++) begin
      v = {k[1], k[0], 6'h01};
      wb_write(`THROTTLE_ADDR, {24'h000000, v});
      i_cpu_periph_model.fire(9);
      wb_read(`THROTTLE_ADDR, {v[7], v[6] & ~v[7], 1'b0, v[6], 4'h1});
      if (k == 1) begin
        wait_run(1'b0, p);
        wait_run(1'b1, p);
        wait_run(1'b1, p);
        check(p, 4);
      end else begin
        wait_run(1'b0, p);
        check(p, 600);
      end
      // service code flips the exit bit before returning
      wb_write(`THROTTLE_ADDR,
               {24'h0, v[7], v[6] & ~v[7], 1'b0, ~v[6], 4'h1});
      i_cpu_periph_model.fire(10);
      wb_read(`THROTTLE_ADDR, {v[7], ~v[6], 1'b0, ~v[6], 4'h1});
      wb_write(`THROTTLE_ADDR, 32'h00000000);
    end
    repeat (3) @(posedge mclk);
    if (exp_q.size() != 0) bad_count++;
    print_verdict();
  end
endmodule

// [verilog/flag_byte.sv]
`timescale 1ns/100ps
// one byte of sticky request flags; unimplemented bits are held at zero
module flag_byte #(
  parameter logic [7:0] MASK = 8'hFF
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] hw_set,   // one-cycle event per bit
  input  wire logic       sw_wr,    // software write strobe
  input  wire logic [7:0] sw_data,  // software write value
  output logic      [7:0] flags_q   // current flags
);

  logic [7:0] flags_d;

  // per bit next value: a set in the clearing cycle still lands
  for (genvar b = 0; b < 8; b++) begin : g_bit
    always_comb begin
      if (!MASK[b]) begin
        flags_d[b] = 1'b0;
      end else if (sw_wr) begin
        flags_d[b] = sw_data[b] | hw_set[b];
      end else begin
        flags_d[b] = flags_q[b] | hw_set[b];
      end
    end
  end

  // registered flags, cleared by every reset
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q <= 8'h00;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule

// [verilog/irq_doze_defines.svh]
// Operation
// - sixth flags: unit2 bit1, unit1 bit0
// - capture or compare event sets unit flag
// - pwm trailing edge sets unit flag
// - nonvolatile done sets seventh flags bit5
// - oscillator rollover sets seventh flags bit4
// - waveform shutdown sets seventh flags bit0
// - unimplemented bits read zero, ignore writes
// - flags hardware set, writable, reset zero
// - enables mirror flags; global control fields
// - throttle runs cpu one cycle in N
// - ratio 100 gives one in 32
// - ratio 001 gives one in 4
// - peripherals keep full clock while throttled
// - interrupt entry copies enable to exit bit
// - no recovery keeps throttle during service
// - recovery clears throttle enable on entry
// - throttle off runs everything full speed
// - exit bit stays writable inside service
`ifndef IRQ_DOZE_DEFINES_SVH
`define IRQ_DOZE_DEFINES_SVH

// register byte addresses, one aligned word each
`define GCTL_ADDR      8'h00
`define ENABLE_BASE    8'h04
`define FLAGS_BASE     8'h24
`define THROTTLE_ADDR  8'h44
`define BANK_REGS      8

// implemented bit masks, register 0 in the low byte
`define BANK_MASKS     64'h3103_F103_FF43_C131
`define GCTL_MASK      8'hC1
`define THROTTLE_MASK  8'hD7

// global control fields
`define GLOBAL_EN_BIT  7
`define PERIPH_EN_BIT  6
`define EDGE_BIT       0

// flag positions
`define CAP1_BIT       0
`define CAP2_BIT       1
`define NVM_BIT        5
`define NCO_BIT        4
`define CWG_BIT        0
`define CAP_REG        6
`define MISC_REG       7

// throttle control fields
`define RECOVER_BIT    7
`define TEN_BIT        6
`define EXIT_BIT       4
`define RATIO_LSB      0

// reset values
`define REG_RESET      8'h00

`endif

// [verilog/irq_doze_pkg.sv]
package irq_doze_pkg;

  // capture/compare/pwm unit operating mode
  typedef enum logic [1:0] {
    UNIT_OFF     = 2'h0,
    UNIT_CAPTURE = 2'h1,
    UNIT_COMPARE = 2'h2,
    UNIT_PWM     = 2'h3
  } unit_mode_t;

  // throttle pacer states, gray along full -> active -> idle
  typedef enum logic [1:0] {
    PACE_FULL   = 2'h0,
    PACE_ACTIVE = 2'h1,
    PACE_IDLE   = 2'h3
  } pace_state_t;

endpackage

// [verilog/irq_flags_doze_control.sv]
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
`include "irq_doze_defines.svh"
// interrupt flag bank, enables, global control and cpu throttle control
module irq_flags_doze_control #(
  parameter int AW = 8
) (
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  // classic wishbone slave
  input  wire logic [AW-1:0] wb_adr_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  input  wire logic          wb_we_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  output logic               wb_ack_o,
  // capture/compare/pwm units
  input  wire logic [1:0]    capture_unit1_mode,
  input  wire logic          unit1_capture,
  input  wire logic          unit1_compare_match,
  input  wire logic          unit1_pwm_trailing,
  input  wire logic [1:0]    capture_unit2_mode,
  input  wire logic          unit2_capture,
  input  wire logic          unit2_compare_match,
  input  wire logic          unit2_pwm_trailing,
  // other peripheral events
  input  wire logic          nonvolatile_done,
  input  wire logic          oscillator_rollover,
  input  wire logic          waveform_shutdown,
  // cpu core
  input  wire logic          irq_taken,
  input  wire logic          irq_return,
  output logic               irq_request,
  output logic               external_edge_select,
  output logic               cpu_run,
  output logic               periph_run
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic          req;        // live request not yet answered
  logic          wr_lane0;   // write that carries byte lane 0
  logic          hit_gctl;   // global control selected
  logic          hit_thr;    // throttle control selected
  logic          hit_en;     // an enable register selected
  logic          hit_fl;     // a flag register selected
  logic [AW-1:0] en_off;     // offset inside enable bank
  logic [AW-1:0] fl_off;     // offset inside flag bank
  logic [2:0]    bank_idx;   // selected bank entry

  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_lane0 = req & wb_we_i & wb_sel_i[0];
  assign en_off   = wb_adr_i - AW'(`ENABLE_BASE);
  assign fl_off   = wb_adr_i - AW'(`FLAGS_BASE);
  assign hit_gctl = (wb_adr_i == AW'(`GCTL_ADDR));
  assign hit_thr  = (wb_adr_i == AW'(`THROTTLE_ADDR));
  // word aligned and inside the eight entry window
  assign hit_en   = (en_off[1:0] == 2'h0) && (en_off < AW'(32));
  assign hit_fl   = (fl_off[1:0] == 2'h0) && (fl_off < AW'(32));
  assign bank_idx = hit_en ? en_off[4:2] : fl_off[4:2];

  // ---------------------------------------------------------------
  // global control register
  // ---------------------------------------------------------------
  logic [7:0] gctl_q;  // global enable, peripheral enable, edge
  logic [7:0] gctl_d;

  // next value: only implemented bits take the write
  always_comb begin
    gctl_d = gctl_q;
    if (wr_lane0 && hit_gctl) begin
      gctl_d = wb_dat_i[7:0] & `GCTL_MASK;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      gctl_q <= `REG_RESET;
    end else begin
      gctl_q <= gctl_d;
    end
  end

  // ---------------------------------------------------------------
  // enable bank: same bit positions as the flags
  // ---------------------------------------------------------------
  logic [7:0] en_q [`BANK_REGS];
  logic [7:0] en_d [`BANK_REGS];

  // all bank masks in one word; a literal cannot be sliced directly
  localparam logic [63:0] BANK_MASK_ALL = `BANK_MASKS;

  // next values of the enable registers
  always_comb begin
    for (int i = 0; i < `BANK_REGS; i++) begin
      en_d[i] = en_q[i];
      if (wr_lane0 && hit_en && (bank_idx == 3'(i))) begin
        en_d[i] = wb_dat_i[7:0] & BANK_MASK_ALL[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < `BANK_REGS; i++) begin
        en_q[i] <= `REG_RESET;
      end
    end else begin
      en_q <= en_d;
    end
  end

  // ---------------------------------------------------------------
  // flag bank: event selection per unit mode
  // ---------------------------------------------------------------
  logic       unit1_event;  // unit 1 event of its current mode
  logic       unit2_event;  // unit 2 event of its current mode
  logic [7:0] set_vec [`BANK_REGS];
  logic [7:0] flags   [`BANK_REGS];

  // the event that counts depends on the unit's mode
  always_comb begin
    case (irq_doze_pkg::unit_mode_t'(capture_unit1_mode))
      irq_doze_pkg::UNIT_CAPTURE: unit1_event = unit1_capture;
      irq_doze_pkg::UNIT_COMPARE: unit1_event = unit1_compare_match;
      irq_doze_pkg::UNIT_PWM:     unit1_event = unit1_pwm_trailing;
      default:                    unit1_event = 1'b0;
    endcase
    case (irq_doze_pkg::unit_mode_t'(capture_unit2_mode))
      irq_doze_pkg::UNIT_CAPTURE: unit2_event = unit2_capture;
      irq_doze_pkg::UNIT_COMPARE: unit2_event = unit2_compare_match;
      irq_doze_pkg::UNIT_PWM:     unit2_event = unit2_pwm_trailing;
      default:                    unit2_event = 1'b0;
    endcase
  end

  // route events to their flag positions; earlier registers have none
  always_comb begin
    for (int i = 0; i < `BANK_REGS; i++) begin
      set_vec[i] = 8'h00;
    end
    set_vec[`CAP_REG][`CAP1_BIT]  = unit1_event;
    set_vec[`CAP_REG][`CAP2_BIT]  = unit2_event;
    set_vec[`MISC_REG][`NVM_BIT]  = nonvolatile_done;
    set_vec[`MISC_REG][`NCO_BIT]  = oscillator_rollover;
    set_vec[`MISC_REG][`CWG_BIT]  = waveform_shutdown;
  end

  // one sticky flag byte per bank entry
  for (genvar r = 0; r < `BANK_REGS; r++) begin : g_flags
    flag_byte #(
      .MASK (BANK_MASK_ALL[r*8 +: 8])
    ) u_flags (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .hw_set  (set_vec[r]),
      .sw_wr   (wr_lane0 && hit_fl && (bank_idx == 3'(r))),
      .sw_data (wb_dat_i[7:0]),
      .flags_q (flags[r])
    );
  end

  // ---------------------------------------------------------------
  // throttle control register and interrupt entry/return
  // ---------------------------------------------------------------
  logic [7:0] thr_q;  // recover, enable, exit bit, ratio
  logic [7:0] thr_d;

  // hardware entry and return win over a software write in that cycle
  always_comb begin
    thr_d = thr_q;
    if (wr_lane0 && hit_thr) begin
      thr_d = wb_dat_i[7:0] & `THROTTLE_MASK;
    end
    if (irq_taken) begin
      thr_d[`EXIT_BIT] = thr_q[`TEN_BIT];
      if (thr_q[`TEN_BIT] && thr_q[`RECOVER_BIT]) begin
        thr_d[`TEN_BIT] = 1'b0;
      end else begin
        thr_d[`TEN_BIT] = thr_q[`TEN_BIT];
      end
    end else if (irq_return) begin
      thr_d[`TEN_BIT] = thr_q[`EXIT_BIT];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      thr_q <= `REG_RESET;
    end else begin
      thr_q <= thr_d;
    end
  end

  // cpu pacing
  irq_doze_pkg::pace_state_t pace_state;

  throttle_pacer #(
    .RATIO_W (3),
    .CNT_W   (9)
  ) u_pacer (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .enable  (thr_q[`TEN_BIT]),
    .ratio   (thr_q[`RATIO_LSB +: 3]),
    .cpu_run (cpu_run),
    .state_q (pace_state)
  );

  // peripherals never see the throttle
  assign periph_run = 1'b1;

  // ---------------------------------------------------------------
  // interrupt request level
  // ---------------------------------------------------------------
  logic [7:0] pend [`BANK_REGS];
  logic       any_pend;
  logic       irq_d;
  logic       irq_q;

  // pending means flag and enable at the same position
  always_comb begin
    any_pend = 1'b0;
    for (int i = 0; i < `BANK_REGS; i++) begin
      pend[i]  = flags[i] & en_q[i];
      any_pend = any_pend | (|pend[i]);
    end
    irq_d = gctl_q[`GLOBAL_EN_BIT] & gctl_q[`PERIPH_EN_BIT] & any_pend;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign irq_request          = irq_q;
  assign external_edge_select = gctl_q[`EDGE_BIT];

  // ---------------------------------------------------------------
  // bus answer: ack one cycle after the request, data registered
  // ---------------------------------------------------------------
  logic        ack_d;
  logic        ack_q;
  logic [31:0] rdat_d;
  logic [31:0] rdat_q;

  // read mux; unmapped addresses read zero and are still acked
  always_comb begin
    ack_d  = req;
    rdat_d = rdat_q;
    if (req && !wb_we_i) begin
      if (hit_gctl) begin
        rdat_d = {24'h0, gctl_q};
      end else if (hit_thr) begin
        rdat_d = {24'h0, thr_q};
      end else if (hit_en) begin
        rdat_d = {24'h0, en_q[bank_idx]};
      end else if (hit_fl) begin
        rdat_d = {24'h0, flags[bank_idx]};
      end else begin
        rdat_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_enter_with_recover;
    irq_taken && thr_q[`TEN_BIT] && thr_q[`RECOVER_BIT];
  endsequence

  sequence s_enter_no_recover;
    irq_taken && thr_q[`TEN_BIT] && !thr_q[`RECOVER_BIT];
  endsequence

  // throttle held on at the one in four ratio
  sequence s_pace_four;
    thr_q[`TEN_BIT] && thr_q[2:0] == 3'h1;
  endsequence

  a_cap_flag_sticky: assert property (
    unit1_event |=> flags[`CAP_REG][`CAP1_BIT])
    else $error("unit 1 event did not set its flag");

  a_nvm_flag_set: assert property (
    nonvolatile_done |=> flags[`MISC_REG][`NVM_BIT])
    else $error("nonvolatile done flag not set");

  a_unimpl_zero: assert property (
    (flags[`MISC_REG] & ~8'h31) == 8'h00 && (gctl_q & ~8'hC1) == 8'h00)
    else $error("unimplemented bit is nonzero");

  a_flag_hold: assert property (
    flags[`CAP_REG][`CAP2_BIT] && !(wr_lane0 && hit_fl)
      |=> flags[`CAP_REG][`CAP2_BIT])
    else $error("flag lost without a software write");

  a_exit_copy: assert property (
    irq_taken |=> thr_q[`EXIT_BIT] == $past(thr_q[`TEN_BIT]))
    else $error("exit bit not copied on entry");

  a_recover_clear: assert property (
    s_enter_with_recover |=> !thr_q[`TEN_BIT] ##1 cpu_run)
    else $error("recovery did not restore full speed");

  a_keep_throttle: assert property (
    (s_enter_no_recover and !irq_return) |=> thr_q[`TEN_BIT])
    else $error("throttle dropped without recovery");

  // only judged while software leaves the throttle alone for the period
  a_ratio_four: assert property (
    $rose(cpu_run) && $past(thr_q[`TEN_BIT]) && thr_q[`TEN_BIT]
      && thr_q[2:0] == 3'h1 ##1 s_pace_four [*3]
      |-> !cpu_run && $past(!cpu_run) && $past(!cpu_run, 2) ##1 cpu_run)
    else $error("one in four pacing broken");

  a_full_speed: assert property (
    !thr_q[`TEN_BIT] |=> cpu_run || thr_q[`TEN_BIT])
    else $error("cpu stalled with throttle off");

  a_off_full: assert property (
    !thr_q[`TEN_BIT] |=> pace_state == irq_doze_pkg::PACE_FULL)
    else $error("pacer not in full speed with throttle off");

  a_bus_ack: assert property (
    req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle");

endmodule

// [verilog/throttle_pacer.sv]
`timescale 1ns/100ps
// paces cpu instruction cycles: one active cycle out of every N
module throttle_pacer #(
  parameter int RATIO_W = 3,
  parameter int CNT_W   = 9
) (
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  input  wire logic               enable,   // throttle enable level
  input  wire logic [RATIO_W-1:0] ratio,    // ratio select field
  output logic                    cpu_run,  // cpu may execute this cycle
  output irq_doze_pkg::pace_state_t state_q
);

  irq_doze_pkg::pace_state_t state_d;
  logic [CNT_W-1:0] cnt_q;   // idle cycles still to spend
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] idle_len; // N-1 idle cycles after each active one

  // N is two to the power ratio+1, so idle length is N-1
  assign idle_len = CNT_W'((CNT_W+1)'(2) << ratio) - CNT_W'(1);

  // next state: full speed when off, else active then N-1 idle
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      irq_doze_pkg::PACE_FULL: begin
        if (enable) begin
          state_d = irq_doze_pkg::PACE_ACTIVE;
        end
      end
      irq_doze_pkg::PACE_ACTIVE: begin
        if (!enable) begin
          state_d = irq_doze_pkg::PACE_FULL;
        end else begin
          state_d = irq_doze_pkg::PACE_IDLE;
          cnt_d   = idle_len;
        end
      end
      irq_doze_pkg::PACE_IDLE: begin
        if (!enable) begin
          state_d = irq_doze_pkg::PACE_FULL;
        end else if (cnt_q <= CNT_W'(1)) begin
          state_d = irq_doze_pkg::PACE_ACTIVE;
          cnt_d   = '0;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      default: begin
        state_d = irq_doze_pkg::PACE_FULL;
        cnt_d   = '0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= irq_doze_pkg::PACE_FULL;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // cpu runs in full mode and in the single active cycle
  assign cpu_run = (state_q != irq_doze_pkg::PACE_IDLE);

endmodule
